//--- smi_pkg.sv
package smi_pkg;
	// configuration register (16 bits) and status register offsets
	localparam logic [7:0]  CFG_OFFSET    = 8'h32;
	localparam logic [7:0]  STATUS_OFFSET = 8'h34;
	localparam int          CFG_W         = 16;
	localparam logic [15:0] CFG_RESET     = 16'h0000;
	// configuration field positions
	localparam int CFG_DRAM_BIT  = 0;
	localparam int CFG_SIZE_LSB  = 1;
	localparam int CFG_P_LSB     = 3;
	localparam int CFG_P_W       = 4;
	localparam int CFG_RFI_LSB   = 7;
	localparam int CFG_RFI_W     = 8;
	localparam int CFG_CHAIN_BIT = 15;
	// chip organisation codes held in the size field
	localparam logic [1:0] SZ_SRAM_128K = 2'h0;
	localparam logic [1:0] SZ_SRAM_512K = 2'h1;
	localparam logic [1:0] SZ_DRAM_256K = 2'h0;
	localparam logic [1:0] SZ_DRAM_1M   = 2'h1;
	localparam logic [1:0] SZ_DRAM_4M   = 2'h2;
	// widths
	localparam int HOST_AW  = 24;
	localparam int SRAM_AW  = 20;
	localparam int MEM_AW   = 19;
	localparam int ROW_W    = 11;
	localparam int DATA_W   = 16;
	localparam int N_AGENTS = 5;
	// requester indices, highest priority first
	localparam int AG_RX   = 0;
	localparam int AG_HOST = 1;
	localparam int AG_TX   = 2;
	localparam int AG_IRQ  = 3;
	localparam int AG_REF  = 4;
	// timing
	localparam int CLK_MHZ      = 100;
	localparam int TOKEN_NS     = 30;
	localparam int TOKEN_CYC    = (TOKEN_NS * CLK_MHZ + 999) / 1000;
	localparam int REFRESH_UNIT = 16;
	// memory cycle states
	typedef enum logic [4:0] {
		ST_IDLE  = 5'b00001,
		ST_PH1   = 5'b00010,
		ST_PH2   = 5'b00100,
		ST_PH3   = 5'b01000,
		ST_TOKEN = 5'b10000
	} smi_state_e;
endpackage

//--- smi_arbiter.sv
`timescale 1ns/1ns
module smi_arbiter #(
	parameter int N = 5
) (
	input  wire logic [N-1:0] req,
	output logic      [N-1:0] grant
);
	////////////////////////////////////////////////////////////////////////
	// fixed priority: lowest index wins
	always_comb begin
		grant = '0;
		for (int i = N - 1; i >= 0; i--) begin
			if (req[i]) begin
				grant = '0;
				grant[i] = 1'b1;
			end
		end
	end
endmodule

//--- smi_addr_map.sv
`timescale 1ns/1ns
module smi_addr_map
	import smi_pkg::*;
(
	input  wire logic                dram_mode,
	input  wire logic [1:0]          msize,
	input  wire logic [HOST_AW-1:0]  addr,
	input  wire logic                word,
	input  wire logic                col_phase,
	input  wire logic                refresh,
	input  wire logic [ROW_W-1:0]    ref_row,
	output logic      [7:0]          ce_n,
	output logic      [3:0]          ras_n,
	output logic      [1:0]          cas_n,
	output logic      [MEM_AW-1:0]   maddr
);
	logic [2:0]       ce_idx;
	logic [1:0]       bank;
	logic [ROW_W-1:0] row;
	logic [ROW_W-1:0] col;

	////////////////////////////////////////////////////////////////////////
	// chip enable, bank and row/column split per organisation
	always_comb begin
		ce_idx = {addr[19], addr[18], addr[0]};
		if (msize == SZ_SRAM_512K)
			ce_idx = {2'b00, addr[0]};
		case (msize)
			SZ_DRAM_1M: begin
				bank = {addr[22], addr[20]};
				row  = {1'b0, addr[20:11]};
				col  = {1'b0, addr[10:1]};
			end
			SZ_DRAM_4M: begin
				bank = {1'b0, addr[23]};
				row  = addr[22:12];
				col  = addr[11:1];
			end
			default: begin
				bank = {addr[20], addr[19]};
				row  = {2'b00, addr[18:10]};
				col  = {2'b00, addr[9:1]};
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// strobe and address pins for the current phase
	always_comb begin
		ce_n  = 8'hff;
		ras_n = 4'hf;
		cas_n = 2'h3;
		maddr = '0;
		if (refresh) begin
			ras_n = 4'h0;
			maddr = {8'h00, ref_row};
		end else if (dram_mode) begin
			ras_n[bank] = 1'b0;
			if (col_phase) begin
				maddr = {8'h00, col};
				cas_n = word ? 2'h0 : (addr[0] ? 2'h1 : 2'h2);
			end else begin
				maddr = {8'h00, row};
			end
		end else begin
			ce_n[ce_idx] = 1'b0;
			if (msize == SZ_SRAM_512K)
				maddr = addr[19:1];
			else
				maddr = {2'b00, addr[17:1]};
		end
	end
endmodule

//--- smi_mem_iface.sv
`timescale 1ns/1ns
// Functional notes
// - dram mode reaches up to 16 megabytes through 24 host address bits.
// - sram mode reaches at most 1 megabyte; higher address bits are dropped.
// - memory is always 16 bits wide; byte selection reaches single bytes.
// - one agent at a time owns the memory through the arbiter.
// - every cycle phase lasts p clock periods, p programmed by software with 0 taken as 1.
// - 128k sram: one of eight chip enables, index from address bits 19, 18, 0.
// - 128k sram: 17 address bits from host bits 1 to 17.
// - 512k sram: 19 bits from host 1 to 19; enable 1 when bit 0 set.
// - dram: eleven muxed lines, four row strobes, two column strobes.
// - row-strobe-only refresh over all rows at a programmed rate.
// - 256k dram: bank from bits 20,19; 9-bit row/column from bits 1-18.
// - 1m dram: bank from bits 22,20; 10-bit row/column from bits 1-20.
// - 4m dram: bank from bit 23; 11-bit row/column from bits 1-22.
// - priority: receive dma, host, transmit dma, interrupt, refresh.
// - finished chained device sends a 30 ns token pulse to the next.
module smi_mem_iface
	import smi_pkg::*;
(
	input  wire logic                   clk,
	input  wire logic                   sys_rst,
	input  wire logic                   register_select_n,
	input  wire logic                   memory_select_n,
	input  wire logic [HOST_AW-1:0]     host_addr,
	input  wire logic                   host_write,
	input  wire logic                   host_word,
	input  wire logic [DATA_W-1:0]      host_wdata,
	output logic                        host_ready,
	output logic      [DATA_W-1:0]      reg_rdata,
	input  wire logic                   rx_dma_req,
	input  wire logic [HOST_AW-1:0]     rx_dma_addr,
	input  wire logic                   rx_dma_write,
	input  wire logic [DATA_W-1:0]      rx_dma_wdata,
	output logic                        rx_dma_done,
	input  wire logic                   tx_dma_req,
	input  wire logic [HOST_AW-1:0]     tx_dma_addr,
	output logic                        tx_dma_done,
	input  wire logic                   irq_ctl_req,
	input  wire logic [HOST_AW-1:0]     irq_ctl_addr,
	input  wire logic [DATA_W-1:0]      irq_ctl_wdata,
	output logic                        irq_ctl_done,
	output logic      [DATA_W-1:0]      mem_rd_data,
	output logic      [7:0]             sram_chip_enable_n,
	output logic      [3:0]             row_strobe_n,
	output logic      [1:0]             column_strobe_n,
	output logic      [MEM_AW-1:0]      memory_address_out,
	output logic                        mem_we_n,
	output logic                        mem_oe_n,
	input  wire logic [DATA_W-1:0]      mem_data_in,
	output logic      [DATA_W-1:0]      mem_data_out,
	output logic                        mem_data_oe,
	input  wire logic                   token_in,
	output logic                        token_out
);
	smi_state_e          state;
	smi_state_e          next_state;
	logic [CFG_W-1:0]    memory_interface_config;
	logic [CFG_P_W-1:0]  pcnt;
	logic [1:0]          tcnt;
	logic [15:0]         ref_cnt;
	logic                ref_pending;
	logic [ROW_W-1:0]    ref_row;
	logic                have_token;
	logic                host_served;
	logic [N_AGENTS-1:0] req;
	logic [N_AGENTS-1:0] grant;
	logic [N_AGENTS-1:0] cur_grant;
	logic [HOST_AW-1:0]  cur_addr;
	logic                cur_write;
	logic                cur_word;
	logic [DATA_W-1:0]   cur_wdata;
	logic [HOST_AW-1:0]  pick_addr;
	logic                pick_write;
	logic                pick_word;
	logic [DATA_W-1:0]   pick_wdata;
	logic [HOST_AW-1:0]  map_addr;
	logic [7:0]          map_ce_n;
	logic [3:0]          map_ras_n;
	logic [1:0]          map_cas_n;
	logic [MEM_AW-1:0]   map_maddr;
	logic                dram_mode;
	logic                chain;
	logic [1:0]          msize;
	logic [CFG_P_W-1:0]  p_eff;
	logic                phase_end;
	logic                can_start;
	logic                start;
	logic                is_ref;

	////////////////////////////////////////////////////////////////////////
	// configuration fields
	assign dram_mode = memory_interface_config[CFG_DRAM_BIT];
	assign chain     = memory_interface_config[CFG_CHAIN_BIT];
	assign msize     = memory_interface_config[CFG_SIZE_LSB +: 2];
	assign p_eff     = (memory_interface_config[CFG_P_LSB +: CFG_P_W] == '0) ? 4'h1 :
		memory_interface_config[CFG_P_LSB +: CFG_P_W];
	assign phase_end = (pcnt == p_eff - 4'h1);

	////////////////////////////////////////////////////////////////////////
	// requests and arbitration
	assign req = {ref_pending & dram_mode, irq_ctl_req, tx_dma_req,
		~memory_select_n & ~host_served, rx_dma_req};
	assign can_start = ~chain | have_token;
	assign start = (state == ST_IDLE) && can_start && (|req);
	assign is_ref = cur_grant[AG_REF];

	smi_arbiter #(
		.N     (N_AGENTS)
	) u_arb (
		.req   (req),
		.grant (grant)
	);

	// request fields of the winner
	always_comb begin
		pick_addr  = '0;
		pick_write = 1'b0;
		pick_word  = 1'b1;
		pick_wdata = '0;
		case (1'b1)
			grant[AG_RX]: begin
				pick_addr  = rx_dma_addr;
				pick_write = rx_dma_write;
				pick_wdata = rx_dma_wdata;
			end
			grant[AG_HOST]: begin
				pick_addr  = host_addr;
				pick_write = host_write;
				pick_word  = host_word;
				pick_wdata = host_wdata;
			end
			grant[AG_TX]:  pick_addr = tx_dma_addr;
			grant[AG_IRQ]: begin
				pick_addr  = irq_ctl_addr;
				pick_write = 1'b1;
				pick_wdata = irq_ctl_wdata;
			end
			default: pick_addr = '0;
		endcase
		if (!dram_mode)
			pick_addr[HOST_AW-1:SRAM_AW] = '0;
	end

	////////////////////////////////////////////////////////////////////////
	// cycle sequencer
	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (start)
					next_state = ST_PH1;
				else if (chain && have_token)
					next_state = ST_TOKEN;
			end
			ST_PH1:   if (phase_end) next_state = ST_PH2;
			ST_PH2:   if (phase_end) next_state = ST_PH3;
			ST_PH3:   if (phase_end) next_state = ST_IDLE;
			ST_TOKEN: if (tcnt == 2'(TOKEN_CYC - 1)) next_state = ST_IDLE;
			default:  next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			state <= ST_IDLE;
		else
			state <= next_state;
	end

	// phase length counter
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			pcnt <= '0;
		else if (state == ST_IDLE || phase_end)
			pcnt <= '0;
		else
			pcnt <= pcnt + 4'h1;
	end

	// token pulse length counter
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			tcnt <= '0;
		else if (state == ST_TOKEN)
			tcnt <= tcnt + 2'h1;
		else
			tcnt <= '0;
	end

	// token ownership; an arriving token wins over the hand-off
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			have_token <= 1'b0;
		else if (token_in)
			have_token <= 1'b1;
		else if (state == ST_IDLE && next_state == ST_TOKEN)
			have_token <= 1'b0;
	end

	// latch the granted request at the cycle boundary
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cur_grant <= '0;
			cur_addr  <= '0;
			cur_write <= 1'b0;
			cur_word  <= 1'b1;
			cur_wdata <= '0;
		end else if (start) begin
			cur_grant <= grant;
			cur_addr  <= pick_addr;
			cur_write <= pick_write;
			cur_word  <= pick_word;
			cur_wdata <= pick_wdata;
		end
	end

	// host stays served until it drops memory select
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			host_served <= 1'b0;
		else if (state == ST_PH3 && phase_end && cur_grant[AG_HOST])
			host_served <= 1'b1;
		else if (memory_select_n)
			host_served <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// refresh timer, pending flag and row counter; a new tick beats the clear
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ref_cnt     <= '0;
			ref_pending <= 1'b0;
		end else begin
			if (ref_cnt <= 16'h1) // reload on the last count: period is interval * 16
				ref_cnt <= 16'(memory_interface_config[CFG_RFI_LSB +: CFG_RFI_W]
					* REFRESH_UNIT);
			else
				ref_cnt <= ref_cnt - 16'h1;
			if (ref_cnt == 16'h1 && dram_mode)
				ref_pending <= 1'b1;
			else if (start && grant[AG_REF])
				ref_pending <= 1'b0;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			ref_row <= '0;
		else if (state == ST_PH3 && phase_end && is_ref)
			ref_row <= ref_row + 11'h1;
	end

	////////////////////////////////////////////////////////////////////////
	// address decoding and registered memory pins
	assign map_addr = (state == ST_IDLE) ? pick_addr : cur_addr;

	smi_addr_map u_map (
		.dram_mode (dram_mode),
		.msize     (msize),
		.addr      (map_addr),
		.word      ((state == ST_IDLE) ? pick_word : cur_word),
		.col_phase (next_state == ST_PH2),
		.refresh   ((state == ST_IDLE) ? grant[AG_REF] : is_ref),
		.ref_row   (ref_row),
		.ce_n      (map_ce_n),
		.ras_n     (map_ras_n),
		.cas_n     (map_cas_n),
		.maddr     (map_maddr)
	);

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sram_chip_enable_n <= 8'hff;
			row_strobe_n       <= 4'hf;
			column_strobe_n    <= 2'h3;
			memory_address_out <= '0;
			mem_we_n           <= 1'b1;
			mem_oe_n           <= 1'b1;
			mem_data_out       <= '0;
			mem_data_oe        <= 1'b0;
		end else begin
			sram_chip_enable_n <= 8'hff;
			row_strobe_n       <= 4'hf;
			column_strobe_n    <= 2'h3;
			mem_we_n           <= 1'b1;
			mem_oe_n           <= 1'b1;
			mem_data_oe        <= 1'b0;
			if (next_state == ST_PH1 || next_state == ST_PH2) begin
				sram_chip_enable_n <= map_ce_n;
				row_strobe_n       <= map_ras_n;
				column_strobe_n    <= map_cas_n;
				memory_address_out <= map_maddr;
			end
			if (next_state == ST_PH2 && !is_ref) begin
				mem_we_n     <= ~cur_write;
				mem_oe_n     <= cur_write;
				mem_data_oe  <= cur_write;
				mem_data_out <= cur_wdata;
			end
		end
	end

	// read data capture and completion pulses
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			mem_rd_data  <= '0;
			host_ready   <= 1'b0;
			rx_dma_done  <= 1'b0;
			tx_dma_done  <= 1'b0;
			irq_ctl_done <= 1'b0;
		end else begin
			if (state == ST_PH2 && phase_end && !cur_write)
				mem_rd_data <= mem_data_in;
			host_ready   <= state == ST_PH3 && phase_end && cur_grant[AG_HOST];
			rx_dma_done  <= state == ST_PH3 && phase_end && cur_grant[AG_RX];
			tx_dma_done  <= state == ST_PH3 && phase_end && cur_grant[AG_TX];
			irq_ctl_done <= state == ST_PH3 && phase_end && cur_grant[AG_IRQ];
		end
	end

	// token pin
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			token_out <= 1'b0;
		else
			token_out <= (next_state == ST_TOKEN);
	end

	////////////////////////////////////////////////////////////////////////
	// register writes through the register select; reads decode the offset alone
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			memory_interface_config <= CFG_RESET;
		else if (!register_select_n && host_write && host_addr[7:0] == CFG_OFFSET)
			memory_interface_config <= host_wdata;
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			reg_rdata <= '0;
		else if (host_addr[7:0] == CFG_OFFSET)
			reg_rdata <= memory_interface_config;
		else if (host_addr[7:0] == STATUS_OFFSET)
			reg_rdata <= {8'h00, have_token, ref_pending, 1'b0, state};
		else
			reg_rdata <= '0;
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	AST_GRANT_ONEHOT: assert property ($onehot0(grant))
		else $error("more than one requester granted");
	AST_RX_FIRST: assert property (rx_dma_req |-> grant[AG_RX])
		else $error("receive dma not ranked first");
	AST_REF_LAST: assert property (grant[AG_REF] |-> req[3:0] == '0)
		else $error("refresh granted over another requester");
	AST_NO_MIDCYCLE: assert property (state != ST_IDLE |=> $stable(cur_grant))
		else $error("grant changed during a memory cycle");
	AST_TOKEN_NEEDED: assert property (chain && !have_token |-> !start)
		else $error("cycle started without the token");
	AST_TOKEN_PULSE: assert property ($rose(token_out) |-> token_out [*3] ##1 !token_out)
		else $error("token pulse not three cycles");
	AST_PHASE_LEN: assert property ($rose(state == ST_PH2) |->
		$past(pcnt) == p_eff - 4'h1)
		else $error("phase ended at the wrong count");
	AST_ONE_CE: assert property ($onehot0(~sram_chip_enable_n))
		else $error("several chip enables active");
	AST_CE_INDEX: assert property (state == ST_PH1 && !dram_mode &&
		msize == SZ_SRAM_128K |->
		!sram_chip_enable_n[{cur_addr[19], cur_addr[18], cur_addr[0]}])
		else $error("wrong chip enable for address");
	AST_SRAM_LIMIT: assert property (start && !dram_mode |=>
		cur_addr[HOST_AW-1:SRAM_AW] == '0)
		else $error("sram address beyond 1 megabyte");
	AST_REF_RAS: assert property (state == ST_PH1 && is_ref |->
		row_strobe_n == 4'h0 && column_strobe_n == 2'h3)
		else $error("refresh is not row strobe only");

	COV_HOST_CYCLE: cover property (start && grant[AG_HOST] ##[1:60] host_ready);
	COV_REFRESH: cover property (start && grant[AG_REF]);
	COV_TOKEN: cover property ($rose(token_out));
endmodule

//--- smi_mem_model.sv
`timescale 1ns/1ns
// behavioural 16-bit wide memory on the far side of the memory pins
module smi_mem_model
	import smi_pkg::*;
(
	input  wire logic              clk,
	input  wire logic [MEM_AW-1:0] addr,
	input  wire logic              we_n,
	input  wire logic              oe_n,
	input  wire logic [DATA_W-1:0] wdata,
	output logic      [DATA_W-1:0] rdata
);
	logic [DATA_W-1:0] mem [16];
	logic [DATA_W-1:0] last;
	// preset contents so an unwritten word still reads as a known value
	initial begin
		last = 16'h0000;
		for (int i = 0; i < 16; i++) mem[i] = 16'h3c00 + 16'(i);
	end
	// whole-word store and read; low address bits pick the word
	always @(posedge clk) begin
		if (!we_n) mem[addr[3:0]] <= wdata;
		if (!oe_n) last <= mem[addr[3:0]];
	end
	// a released bus shows the inverse of the last value, never a stale copy
	assign rdata = !oe_n ? mem[addr[3:0]] : ~last;
endmodule

//--- testbench.sv
`timescale 1ns/1ns
module testbench;
	import smi_pkg::*;
	logic               clk, sys_rst, register_select_n, memory_select_n;
	logic               host_write, host_word, host_ready, rx_dma_req, rx_dma_write;
	logic               rx_dma_done, tx_dma_req, tx_dma_done, irq_ctl_req, irq_ctl_done;
	logic               mem_we_n, mem_oe_n, mem_data_oe, token_in, token_out;
	logic [HOST_AW-1:0] host_addr, rx_dma_addr, tx_dma_addr, irq_ctl_addr;
	logic [DATA_W-1:0]  host_wdata, reg_rdata, rx_dma_wdata, irq_ctl_wdata;
	logic [DATA_W-1:0]  mem_rd_data, mem_data_in, mem_data_out;
	logic [7:0]         sram_chip_enable_n, ce_s;
	logic [3:0]         row_strobe_n, ras_s;
	logic [2:0]         we_s;
	logic [1:0]         column_strobe_n, cas_s;
	logic [MEM_AW-1:0]  memory_address_out, row_s, col_s;
	int                 errors, total_checks, p, lat;
	smi_mem_iface smi_mem_iface_inst (.clk(clk), .sys_rst(sys_rst),
		.register_select_n(register_select_n), .memory_select_n(memory_select_n),
		.host_addr(host_addr), .host_write(host_write), .host_word(host_word),
		.host_wdata(host_wdata), .host_ready(host_ready), .reg_rdata(reg_rdata),
		.rx_dma_req(rx_dma_req), .rx_dma_addr(rx_dma_addr), .rx_dma_write(rx_dma_write),
		.rx_dma_wdata(rx_dma_wdata), .rx_dma_done(rx_dma_done), .tx_dma_req(tx_dma_req),
		.tx_dma_addr(tx_dma_addr), .tx_dma_done(tx_dma_done), .irq_ctl_req(irq_ctl_req),
		.irq_ctl_addr(irq_ctl_addr), .irq_ctl_wdata(irq_ctl_wdata),
		.irq_ctl_done(irq_ctl_done), .mem_rd_data(mem_rd_data),
		.sram_chip_enable_n(sram_chip_enable_n), .row_strobe_n(row_strobe_n),
		.column_strobe_n(column_strobe_n), .memory_address_out(memory_address_out),
		.mem_we_n(mem_we_n), .mem_oe_n(mem_oe_n), .mem_data_in(mem_data_in),
		.mem_data_out(mem_data_out), .mem_data_oe(mem_data_oe), .token_in(token_in),
		.token_out(token_out));
	smi_mem_model smi_mem_model_inst (.clk(clk), .addr(memory_address_out), .we_n(mem_we_n),
		.oe_n(mem_oe_n), .wdata(mem_data_out), .rdata(mem_data_in));
	////////////////////////////////////////////////////////////////////////////////
	// clock, reset and watchdog
	always #5 clk = ~clk;
	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		summarize();
	end
	////////////////////////////////////////////////////////////////////////////////
	// comparisons and bus cycles
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk_n(input int got, input int exp);
		total_checks++;
		if (got != exp) begin
			errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic reg_wr(input logic [7:0] off, input logic [15:0] d);
		@(negedge clk);
		register_select_n = 1'b0;
		host_write = 1'b1;
		host_addr = {16'h0000, off};
		host_wdata = d;
		@(negedge clk);
		register_select_n = 1'b1;
		host_write = 1'b0;
	endtask
	task automatic reg_rd(input logic [7:0] off, input logic [15:0] exp);
		@(negedge clk);
		host_addr = {16'h0000, off};
		@(negedge clk);
		chk(24'(reg_rdata), 24'(exp));
	endtask
	task automatic set_cfg(input logic dram, input logic [1:0] sz, input logic [3:0] pp,
		input logic [7:0] rfi, input logic chain);
		reg_wr(CFG_OFFSET, {chain, rfi, pp, sz, dram});
		p = (pp == 4'h0) ? 1 : int'(pp);
	endtask
	// host memory cycle; samples phase 1 and phase 2 outputs, measures latency
	task automatic host_cycle(input logic [23:0] a, input logic wr, input logic w,
		input logic [15:0] d);
		int cnt;
		cnt = 0;
		@(negedge clk);
		memory_select_n = 1'b0;
		host_addr = a;
		host_write = wr;
		host_word = w;
		host_wdata = d;
		do begin
			@(negedge clk);
			cnt++;
			if (cnt == 1) begin
				ce_s = sram_chip_enable_n;
				ras_s = row_strobe_n;
				row_s = memory_address_out;
			end
			if (cnt == p + 1) begin
				cas_s = column_strobe_n;
				col_s = memory_address_out;
				we_s = {mem_data_oe, mem_we_n, mem_oe_n};
			end
		end while (host_ready !== 1'b1 && cnt < 200);
		lat = cnt;
		chk(24'(host_ready), 24'h000001);
		@(negedge clk);
		memory_select_n = 1'b1;
		host_write = 1'b0;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// scenarios
	task automatic t_regs;
		reg_rd(CFG_OFFSET, CFG_RESET);
		reg_rd(STATUS_OFFSET, 16'h0001);
		reg_wr(CFG_OFFSET, 16'h0078);
		reg_wr(8'h36, 16'hffff);
		reg_wr(STATUS_OFFSET, 16'hffff);
		reg_rd(CFG_OFFSET, 16'h0078);
		reg_rd(STATUS_OFFSET, 16'h0001);
	endtask
	task automatic t_sram;
		logic [23:0] a;
		set_cfg(1'b0, SZ_SRAM_128K, 4'h1, 8'h00, 1'b0);
		for (int i = 0; i < 8; i++) begin
			a = {4'hf, 1'(i >> 2), 1'(i >> 1), 17'h0abcd ^ 17'(i), 1'(i)};
			host_cycle(a, 1'b0, 1'b1, 16'h0000);
			chk(24'(ce_s), {16'h0000, ~(8'h01 << i)});
			chk(24'(row_s[16:0]), 24'(a[17:1]));
		end
		set_cfg(1'b0, SZ_SRAM_512K, 4'h1, 8'h00, 1'b0);
		for (int i = 0; i < 2; i++) begin
			a = {4'h0, 19'h5b3c1 ^ 19'(i), 1'(i)};
			host_cycle(a, 1'b0, 1'b1, 16'h0000);
			chk(24'(ce_s), (i == 1) ? 24'h0000fd : 24'h0000fe);
			chk(24'(row_s), 24'(a[19:1]));
		end
		host_cycle(24'h000012, 1'b1, 1'b1, 16'hc3a5);
		chk(24'(we_s), 24'h000005);
		host_cycle(24'h000012, 1'b0, 1'b1, 16'h0000);
		chk(24'(we_s), 24'h000002);
		chk(24'(mem_rd_data), 24'h00c3a5);
	endtask
	task automatic t_dram(input logic [1:0] sz, input logic [23:0] a);
		int n;
		logic [1:0] bank;
		logic [21:0] bits;
		logic [10:0] m, lo, hi, r, c;
		n = 9 + int'(sz);
		bank = (sz == 2'h0) ? {a[20], a[19]} : (sz == 2'h1) ? {a[22], a[20]} : {1'b0, a[23]};
		bits = a[22:1] & 22'((1 << (2 * n)) - 1);
		m = 11'((1 << n) - 1);
		lo = 11'(bits) & m;
		hi = 11'(bits >> n) & m;
		set_cfg(1'b1, sz, 4'h1, 8'h00, 1'b0);
		host_cycle(a, 1'b0, ~a[0], 16'h0000);
		r = row_s[10:0] & m;
		c = col_s[10:0] & m;
		chk(24'(ras_s), 24'(4'(~(4'h1 << bank))));
		chk(24'(cas_s), a[0] ? 24'h000001 : 24'h000000);
		chk(24'((r == hi && c == lo) || (r == lo && c == hi)), 24'h1);
	endtask
	task automatic t_timing;
		logic [3:0] pv [3] = '{4'h0, 4'h3, 4'hf};
		for (int i = 0; i < 3; i++) begin
			set_cfg(1'b0, SZ_SRAM_128K, pv[i], 8'h00, 1'b0);
			host_cycle(24'h000040, 1'b0, 1'b1, 16'h0000);
			chk_n(lat, 3 * p + 1);
		end
	endtask
	task automatic t_prio;
		logic [3:0] dn;
		int k, last;
		k = 0;
		last = 0;
		set_cfg(1'b0, SZ_SRAM_128K, 4'h1, 8'h00, 1'b0);
		@(negedge clk);
		{rx_dma_req, tx_dma_req, irq_ctl_req, memory_select_n} = 4'b1110;
		host_addr = 24'h000100;
		for (int cyc = 1; cyc < 200 && k < 4; cyc++) begin
			@(negedge clk);
			dn = {irq_ctl_done, tx_dma_done, host_ready, rx_dma_done};
			if (dn !== 4'h0) begin
				chk(24'(dn), 24'(4'h1 << k));
				if (k > 0) chk_n(cyc - last, 3 * p + 1);
				last = cyc;
				k++;
				if (rx_dma_done === 1'b1) rx_dma_req = 1'b0;
				if (host_ready === 1'b1) memory_select_n = 1'b1;
				if (tx_dma_done === 1'b1) tx_dma_req = 1'b0;
				if (irq_ctl_done === 1'b1) irq_ctl_req = 1'b0;
			end
		end
		chk_n(k, 4);
	endtask
	task automatic t_refresh;
		int seen, t0;
		logic [MEM_AW-1:0] r0;
		seen = 0;
		t0 = 0;
		set_cfg(1'b1, SZ_DRAM_256K, 4'h1, 8'h01, 1'b0);
		for (int cyc = 0; cyc < 200 && seen < 2; cyc++) begin
			@(negedge clk);
			if (row_strobe_n === 4'h0 && (cyc - t0 > 4 || seen == 0)) begin
				chk(24'(column_strobe_n), 24'h000003);
				if (seen == 1) chk_n(cyc - t0, REFRESH_UNIT);
				if (seen == 1) chk(24'(memory_address_out != r0), 24'h1);
				r0 = memory_address_out;
				t0 = cyc;
				seen++;
			end
		end
		chk_n(seen, 2);
		set_cfg(1'b0, SZ_SRAM_128K, 4'h1, 8'h00, 1'b0);
	endtask
	task automatic t_token;
		int bad, hi;
		bad = 0;
		hi = 0;
		set_cfg(1'b0, SZ_SRAM_128K, 4'h1, 8'h00, 1'b1);
		@(negedge clk);
		memory_select_n = 1'b0;
		host_addr = 24'h000020;
		repeat (20) begin
			@(negedge clk);
			if (sram_chip_enable_n !== 8'hff || host_ready !== 1'b0) bad = 1;
		end
		chk_n(bad, 0);
		token_in = 1'b1;
		repeat (3) @(negedge clk);
		token_in = 1'b0;
		for (int i = 0; i < 40 && host_ready !== 1'b1; i++) @(negedge clk);
		chk(24'(host_ready), 24'h1);
		memory_select_n = 1'b1;
		repeat (20) begin
			@(negedge clk);
			if (token_out === 1'b1) hi++;
		end
		chk_n(hi, TOKEN_CYC);
		set_cfg(1'b0, SZ_SRAM_128K, 4'h1, 8'h00, 1'b0);
	endtask
	task automatic summarize;
		if (errors == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		{clk, register_select_n, memory_select_n, host_write, host_word} = 5'b01110;
		{rx_dma_req, rx_dma_write, tx_dma_req, irq_ctl_req, token_in} = 5'b00000;
		{host_addr, rx_dma_addr, tx_dma_addr, irq_ctl_addr} = {24'h0, 24'h200, 24'h300, 24'h400};
		{host_wdata, rx_dma_wdata, irq_ctl_wdata} = {16'h0, 16'h1111, 16'h2222};
		errors = 0;
		total_checks = 0;
		p = 1;
		sys_rst = 1'b1;
		repeat (8) @(posedge clk);
		@(negedge clk);
		sys_rst = 1'b0;
		t_regs();
		t_sram();
		t_dram(SZ_DRAM_256K, 24'h2aaaab);
		t_dram(SZ_DRAM_1M, 24'hd55554);
		t_dram(SZ_DRAM_4M, 24'h9ab3c5);
		t_timing();
		t_prio();
		t_refresh();
		t_token();
		summarize();
	end
endmodule
